// File: include/psa_pkg.sv
// How it works
// - Table address is page above effective address
// - Page top bit selects configuration memory
// - Visibility address: page above low fifteen bits
// - Redirect only when bit15 and enable set
// - Upper data half maps to 256 pages
// - Table accesses unaligned, reads reach configuration
// - Config writes refused, reads only implemented areas
// - Low read: word or selected byte
// - High read: upper byte, phantom byte zero
// - Addresses step two per program word
// - Fetch address bit zero forced low
// - Visibility suspended during table access
// - Visibility read outside repeat stretches moves one cycle, others two
// - Outside repeat: one or two extra cycles
// - Repeat loop: edge iterations cost two
// - Write rows 64, erase blocks 512 instructions
package psa_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_TABLE_PAGE = 4'h0;
  localparam logic [3:0] ADDR_VIS_PAGE = 4'h4;
  localparam logic [3:0] ADDR_CORE_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [15:0] RST_CORE_CONTROL = 16'h0000;
  localparam int VIS_ENABLE_BIT = 2;
  localparam int CONFIG_SEL_BIT = 7;
  localparam int EA_TOP_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Memory geometry
  // ****************************************************************
  localparam logic [10:0] WRITE_ROW_INSTR = 11'h040;
  localparam logic [10:0] WRITE_ROW_BYTES = 11'h0c0;
  localparam logic [10:0] ERASE_BLOCK_INSTR = 11'h200;
  localparam logic [10:0] ERASE_BLOCK_BYTES = 11'h600;
  localparam logic [15:0] CONFIG_IMPL_LO = 16'hff00;
  localparam logic [15:0] CONFIG_IMPL_HI = 16'hff03;
  // ****************************************************************
  // Core request carrier
  // ****************************************************************
  typedef enum logic [1:0] {
    PSA_OP_RDL = 2'h0,
    PSA_OP_RDH = 2'h1,
    PSA_OP_WTL = 2'h2,
    PSA_OP_WTH = 2'h3
  } psa_op_t;
  typedef struct packed {
    logic table_req;
    psa_op_t op;
    logic byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
  } psa_table_req_t;
  typedef struct packed {
    logic data_req;
    logic [15:0] ea;
    logic is_move;
    logic in_repeat;
    logic repeat_edge;
  } psa_data_req_t;
  typedef enum logic [2:0] {
    PSA_IDLE = 3'b001,
    PSA_FETCH2 = 3'b010,
    PSA_FETCH3 = 3'b100
  } psa_state_t;
endpackage : psa_pkg

// File: core/psa_unit.sv
`timescale 1ns/100ps
module psa_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire psa_pkg::psa_table_req_t table_req,
  input wire psa_pkg::psa_data_req_t data_req,
  input wire logic [22:0] fetch_pc,
  output logic [23:0] prog_addr,
  output logic prog_rd,
  output logic prog_wr,
  output logic [23:0] prog_wdata,
  output logic [23:0] prog_wmask,
  input wire logic [23:0] prog_rdata,
  output logic [23:0] fetch_addr,
  output logic [15:0] core_rdata,
  output logic core_rvalid,
  output logic core_stall,
  output logic table_refused,
  output logic [10:0] write_row_instr,
  output logic [10:0] erase_block_instr
);
  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic [7:0] table_page_select;
  logic [7:0] visibility_page_select;
  logic [15:0] core_control_register;
  logic refused_sticky;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  // Address and data may come in either order; hold each until both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= psa_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > psa_pkg::ADDR_STATUS) ? psa_pkg::RESP_SLVERR
                                                        : psa_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Page registers and core control, byte-lane writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      table_page_select <= psa_pkg::RST_PAGE;
      visibility_page_select <= psa_pkg::RST_PAGE;
      core_control_register <= psa_pkg::RST_CORE_CONTROL;
    end else if (do_write) begin
      unique case (aw_addr)
        psa_pkg::ADDR_TABLE_PAGE: if (w_strb[0]) table_page_select <= w_data[7:0];
        psa_pkg::ADDR_VIS_PAGE: if (w_strb[0]) visibility_page_select <= w_data[7:0];
        psa_pkg::ADDR_CORE_CONTROL: begin
          if (w_strb[0]) core_control_register[7:0] <= w_data[7:0];
          if (w_strb[1]) core_control_register[15:8] <= w_data[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel; the status word clears nothing, refusals stay sticky until reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= psa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= psa_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        psa_pkg::ADDR_TABLE_PAGE: s_axi_rdata <= {24'h000000, table_page_select};
        psa_pkg::ADDR_VIS_PAGE: s_axi_rdata <= {24'h000000, visibility_page_select};
        psa_pkg::ADDR_CORE_CONTROL: s_axi_rdata <= {16'h0000, core_control_register};
        psa_pkg::ADDR_STATUS: s_axi_rdata <= {29'h0, refused_sticky, core_stall,
                                              table_page_select[psa_pkg::CONFIG_SEL_BIT]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= psa_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ****************************************************************
  // Address generation
  // ****************************************************************
  logic to_config;
  logic config_impl;
  logic vis_hit;
  logic table_active;
  logic tbl_write;
  logic wr_refuse;
  logic rd_refuse;
  logic [23:0] table_addr;
  logic [23:0] vis_addr;

  // Byte address kept whole: table accesses need no alignment
  assign table_addr = {table_page_select, table_req.ea};
  assign to_config = table_page_select[psa_pkg::CONFIG_SEL_BIT];
  assign config_impl = (table_req.ea >= psa_pkg::CONFIG_IMPL_LO) &&
                       (table_req.ea <= psa_pkg::CONFIG_IMPL_HI);
  assign table_active = table_req.table_req;
  assign tbl_write = table_req.op[1];
  assign wr_refuse = table_active && tbl_write && to_config;
  assign rd_refuse = table_active && !tbl_write && to_config && !config_impl;
  // Bit 23 fixed low so visibility never lands in configuration space
  assign vis_addr = {1'b0, visibility_page_select,
                     data_req.ea[psa_pkg::EA_TOP_BIT-1:0]};
  assign vis_hit = data_req.data_req && data_req.ea[psa_pkg::EA_TOP_BIT] &&
                   core_control_register[psa_pkg::VIS_ENABLE_BIT] &&
                   !table_active;
  assign fetch_addr = {fetch_pc, 1'b0};
  assign table_refused = wr_refuse || rd_refuse;
  assign write_row_instr = psa_pkg::WRITE_ROW_INSTR;
  assign erase_block_instr = psa_pkg::ERASE_BLOCK_INSTR;

  // Memory port; table access wins over visibility
  always_comb begin
    prog_addr = 24'h000000;
    prog_rd = 1'b0;
    prog_wr = 1'b0;
    prog_wdata = 24'h000000;
    prog_wmask = 24'h000000;
    if (table_active) begin
      prog_addr = {table_addr[23:1], 1'b0};
      prog_rd = !tbl_write && !rd_refuse;
      prog_wr = tbl_write && !wr_refuse;
      if (table_req.op == psa_pkg::PSA_OP_WTL) begin
        if (!table_req.byte_mode) begin
          prog_wdata = {8'h00, table_req.wdata};
          prog_wmask = 24'h00ffff;
        end else if (table_req.ea[0]) begin
          prog_wdata = {8'h00, table_req.wdata[7:0], 8'h00};
          prog_wmask = 24'h00ff00;
        end else begin
          prog_wdata = {16'h0000, table_req.wdata[7:0]};
          prog_wmask = 24'h0000ff;
        end
      end else if (tbl_write && !(table_req.byte_mode && table_req.ea[0])) begin
        prog_wdata = {table_req.wdata[7:0], 16'h0000};
        prog_wmask = 24'hff0000;
      end
    end else if (vis_hit) begin
      prog_addr = vis_addr;
      prog_rd = 1'b1;
    end
  end

  // ****************************************************************
  // Read data steering
  // ****************************************************************
  function automatic logic [15:0] steer(input psa_pkg::psa_op_t op, input logic bmode,
                                        input logic bsel, input logic [23:0] w);
    logic [15:0] r;
    r = 16'h0000;
    if (op == psa_pkg::PSA_OP_RDL) begin
      if (!bmode) r = w[15:0];
      else r = {8'h00, bsel ? w[15:8] : w[7:0]};
    end else if (!(bmode && bsel)) begin
      r = {8'h00, w[23:16]};
    end
    return r;
  endfunction : steer

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_rdata <= 16'h0000;
      core_rvalid <= 1'b0;
    end else begin
      core_rvalid <= (table_active && !tbl_write) || vis_hit;
      if (table_active && !tbl_write) begin
        core_rdata <= rd_refuse ? 16'h0000 : steer(table_req.op, table_req.byte_mode,
                                                     table_req.ea[0], prog_rdata);
      end else if (vis_hit) begin
        core_rdata <= prog_rdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) refused_sticky <= 1'b0;
    else if (table_refused) refused_sticky <= 1'b1;
  end

  // ****************************************************************
  // Stall sequencer for visibility reads
  // ****************************************************************
  psa_pkg::psa_state_t state;
  psa_pkg::psa_state_t next_state;
  logic two_extra;

  // Outside repeat moves pay one cycle, others two; repeat edge iterations two, steady ones none
  assign two_extra = data_req.in_repeat ? data_req.repeat_edge : !data_req.is_move;

  always_comb begin
    next_state = state;
    unique case (state)
      psa_pkg::PSA_IDLE: begin
        if (vis_hit && (!data_req.in_repeat || data_req.repeat_edge)) begin
          next_state = psa_pkg::PSA_FETCH2;
        end
      end
      psa_pkg::PSA_FETCH2: next_state = two_extra ? psa_pkg::PSA_FETCH3
                                                   : psa_pkg::PSA_IDLE;
      psa_pkg::PSA_FETCH3: next_state = psa_pkg::PSA_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state <= psa_pkg::PSA_IDLE;
    else state <= next_state;
  end
  assign core_stall = (state != psa_pkg::PSA_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_vis_start;
    vis_hit && !data_req.in_repeat && data_req.is_move && state == psa_pkg::PSA_IDLE;
  endsequence
  a_move_one_extra: assert property (@(posedge clk) disable iff (sys_rst)
    s_vis_start |=> core_stall ##1 !core_stall)
    else $error("move visibility stall not one cycle");
  a_other_two_extra: assert property (@(posedge clk) disable iff (sys_rst)
    (vis_hit && !data_req.in_repeat && !data_req.is_move && state == psa_pkg::PSA_IDLE)
    |=> core_stall [*2] ##1 !core_stall)
    else $error("visibility stall not two cycles");
  a_repeat_steady: assert property (@(posedge clk) disable iff (sys_rst)
    (vis_hit && data_req.in_repeat && !data_req.repeat_edge && !core_stall)
    |=> !core_stall)
    else $error("steady repeat iteration stalled");
  a_vis_addr_map: assert property (@(posedge clk) disable iff (sys_rst)
    vis_hit |-> prog_addr == {1'b0, visibility_page_select, data_req.ea[14:0]})
    else $error("visibility address wrong");
  a_vis_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (!core_control_register[2] && !table_active) |-> !prog_rd)
    else $error("redirect without enable");
  a_table_addr: assert property (@(posedge clk) disable iff (sys_rst)
    table_active |-> prog_addr[23:1] == {table_page_select, table_req.ea[15:1]})
    else $error("table address wrong");
  a_config_nowrite: assert property (@(posedge clk) disable iff (sys_rst)
    (table_active && table_page_select[7] && tbl_write) |-> !prog_wr && table_refused)
    else $error("configuration write not refused");
  a_phantom_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (table_active && table_req.op == psa_pkg::PSA_OP_RDH)
    |=> core_rvalid && core_rdata[15:8] == 8'h00)
    else $error("phantom byte not zero");
  a_fetch_align: assert property (@(posedge clk) disable iff (sys_rst)
    fetch_addr[0] == 1'b0 && fetch_addr[23:1] == fetch_pc)
    else $error("fetch address misaligned");
  a_page_reset: assert property (@(posedge clk)
    $past(sys_rst) |-> table_page_select == 8'h00 && visibility_page_select == 8'h00)
    else $error("page register reset wrong");
endmodule : psa_unit

// File: sim/psa_prog_mem.sv
`timescale 1ns/100ps
// ****************************************************************
// Program memory array model
// ****************************************************************
module psa_prog_mem (
  input wire logic [23:0] prog_addr,
  input wire logic prog_rd,
  output logic [23:0] prog_rdata
);
  logic [23:0] word;
  // Upper byte all ones or all zeros, as software pads visibility words
  assign word = {{8{~prog_addr[1]}}, prog_addr[16:1] ^ 16'h5a5a};
  // Idle bus shows the inverse so stale data never matches
  assign prog_rdata = prog_rd ? word : ~word;
endmodule : psa_prog_mem

// File: sim/test_psa_unit.sv
`timescale 1ns/100ps
// ****************************************************************
// Bench top
// ****************************************************************
module test_psa_unit;
  logic clk = 0, sys_rst = 1;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  psa_pkg::psa_table_req_t treq = '0;
  psa_pkg::psa_data_req_t dreq = '0;
  logic [22:0] fetch_pc = 23'h2a5a5b;
  logic [23:0] prog_addr, prog_rdata, fetch_addr, p, wd, wm;
  logic [10:0] row_n, blk_n;
  logic [15:0] core_rdata;
  logic prog_rd, prog_wr, core_rvalid, core_stall, refused;
  int err_total = 0, checks = 0, cyc = 0, n;
  always #50 clk = ~clk;
  psa_unit uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .table_req(treq), .data_req(dreq), .fetch_pc(fetch_pc),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_wr(prog_wr), .prog_wdata(wd),
    .prog_wmask(wm), .prog_rdata(prog_rdata), .fetch_addr(fetch_addr),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid), .core_stall(core_stall),
    .table_refused(refused), .write_row_instr(row_n), .erase_block_instr(blk_n));
  psa_prog_mem mem (.prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata));
  // Same word pattern as the memory model
  function automatic logic [23:0] pat(input logic [23:0] a);
    return {{8{~a[1]}}, a[16:1] ^ 16'h5a5a};
  endfunction : pat
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Hang guard, well beyond the hundred or so cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'h3; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk("bresp", e, bresp);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rs = rresp; rd = rdata;
    rready <= 0;
    chk("rresp", e, rs);
    chk("rdata", d, rd);
  endtask : axi_rd
  // Table access: address and refusal in the cycle, data one edge later
  task automatic tbl(input psa_pkg::psa_op_t op, input logic bm, input logic [15:0] ea,
                     input logic [7:0] pg, input logic rf, input logic [15:0] e);
    @(posedge clk);
    treq <= {1'b1, op, bm, ea, 16'h0f0f};
    @(negedge clk);
    chk("tbl_addr", {pg, ea[15:1]}, prog_addr[23:1]);
    chk("refused", rf, refused);
    chk("prog_wr", op[1] & !rf, prog_wr);
    chk("prog_rd", !op[1] & !rf, prog_rd);
    if (op[1] && !bm && !rf) chk("prog_wdata", op[0] ? 24'h0f0000 : 24'h000f0f, wd);
    if (op[1] && !bm && !rf) chk("prog_wmask", op[0] ? 24'hff0000 : 24'h00ffff, wm);
    @(posedge clk);
    treq <= '0;
    @(negedge clk);
    chk("core_rvalid", !op[1], core_rvalid);
    if (!op[1]) chk("core_rdata", e, core_rdata);
  endtask : tbl
  // Data access held through the stall, extra cycles counted
  task automatic vis(input logic [15:0] ea, input logic mv, input logic rp, input logic ed,
                     input logic tb, input logic hit, input int en);
    @(posedge clk);
    dreq <= {1'b1, ea, mv, rp, ed};
    if (tb) treq <= {1'b1, psa_pkg::PSA_OP_RDL, 1'b0, ea, 16'h0000};
    @(negedge clk);
    if (hit) chk("vis_addr", {1'b0, 8'h34, ea[14:0]}, prog_addr);
    if (!hit && !tb) chk("prog_rd", 0, prog_rd);
    if (tb) chk("tbl_wins", {8'h12, ea[15:1], 1'b0}, prog_addr);
    p = pat({1'b0, 8'h34, ea[14:0]});
    n = 0;
    // Core holds its request for the expected stall, drops it on the last edge;
    // holding longer would look like a fresh access to the sequencer
    @(posedge clk);
    for (int i = 0; i < en + 2; i++) begin
      if (i == en) begin
        dreq <= '0;
        treq <= '0;
      end
      @(negedge clk);
      if (i == 0 && hit) chk("vis_data", p[15:0], core_rdata);
      if (core_stall === 1'b1) n++;
      @(posedge clk);
    end
    chk("stall_cycles", en, n);
  endtask : vis
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    axi_rd(4'h0, 0, 0);
    axi_rd(4'h4, 0, 0);
    axi_rd(4'h8, 0, 0);
    axi_wr(4'h0, 32'h12, 0);
    axi_wr(4'h4, 32'h34, 0);
    axi_wr(4'h8, 32'h4, 0);
    axi_rd(4'h0, 32'h12, 0);
    axi_rd(4'h4, 32'h34, 0);
    axi_rd(4'hd, 0, 2'h2);
    axi_wr(4'hd, 32'h1, 2'h2);
  endtask : t_regs
  task automatic t_table;
    p = pat(24'h122344);
    tbl(psa_pkg::PSA_OP_RDL, 0, 16'h2345, 8'h12, 0, p[15:0]);
    tbl(psa_pkg::PSA_OP_RDL, 1, 16'h2345, 8'h12, 0, {8'h00, p[15:8]});
    tbl(psa_pkg::PSA_OP_RDL, 1, 16'h2344, 8'h12, 0, {8'h00, p[7:0]});
    tbl(psa_pkg::PSA_OP_RDH, 0, 16'h2344, 8'h12, 0, {8'h00, p[23:16]});
    tbl(psa_pkg::PSA_OP_RDH, 1, 16'h2344, 8'h12, 0, {8'h00, p[23:16]});
    tbl(psa_pkg::PSA_OP_RDH, 1, 16'h2345, 8'h12, 0, 16'h0000);
    tbl(psa_pkg::PSA_OP_WTL, 0, 16'h0100, 8'h12, 0, 0);
    tbl(psa_pkg::PSA_OP_WTH, 0, 16'h0102, 8'h12, 0, 0);
    axi_wr(4'h0, 32'h80, 0);
    p = pat(24'h80ff02);
    tbl(psa_pkg::PSA_OP_WTL, 0, 16'hff00, 8'h80, 1, 0);
    tbl(psa_pkg::PSA_OP_RDL, 0, 16'hff02, 8'h80, 0, p[15:0]);
    tbl(psa_pkg::PSA_OP_RDL, 0, 16'h1000, 8'h80, 1, 16'h0000);
    axi_rd(4'hc, 32'h5, 0);
    axi_wr(4'h0, 32'h12, 0);
  endtask : t_table
  task automatic t_vis;
    vis(16'h8124, 1, 0, 0, 0, 1, 1);
    vis(16'hc0f2, 0, 0, 0, 0, 1, 2);
    vis(16'h8124, 0, 1, 0, 0, 1, 0);
    vis(16'hfffe, 1, 1, 1, 0, 1, 2);
    vis(16'h7ffe, 0, 0, 0, 0, 0, 0);
    vis(16'h8124, 0, 0, 0, 1, 0, 0);
    axi_wr(4'h8, 32'h0, 0);
    vis(16'h8124, 0, 0, 0, 0, 0, 0);
  endtask : t_vis
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    t_regs();
    t_table();
    t_vis();
    chk("fetch_addr", {fetch_pc, 1'b0}, fetch_addr);
    chk("write_row", 64, row_n);
    chk("erase_block", 512, blk_n);
    print_verdict();
  end
endmodule : test_psa_unit
